/* dv/wtm_core_tb.sv */
`timescale 1ns/1ps
module wtm_core_tb;
    // ==========================================================
    // stimulus and observation
    logic        clock = 1'b0;
    logic        sys_rst = 1'b1;
    logic [7:0]  reg_addr = 8'h00;
    logic        reg_wr_en = 1'b0;
    logic        reg_rd_en = 1'b0;
    logic [7:0]  reg_wr_data = 8'h00;
    logic [7:0]  reg_rd_data;
    logic        stop_enter = 1'b0;
    logic        ext_wake = 1'b0;
    logic        cpu_clock_enable;
    logic        stab_done;
    logic        watchdog_reset;
    logic        capture_select = 1'b0;
    logic        timer_ext_clock_in = 1'b0;
    logic        timer_capture_in = 1'b0;
    logic        timer_pulse_out;
    logic        overflow_irq_ack = 1'b0;
    logic        timer_overflow_irq;
    logic        timer_match_irq;
    int          fail_count = 0;
    int          checked = 0;
    int          wd_pulses = 0;
    int          seed = 32'h60D41559;
    logic [8:0]  exp_q[$];
    logic [8:0]  note;
    logic        rd_pend = 1'b0;
    logic [7:0]  rd_last = 8'h00;

    // 25 ns period, free running
    always #12.5 clock = ~clock;

    wtm_core dut (
        .clock              (clock),
        .sys_rst            (sys_rst),
        .reg_addr           (reg_addr),
        .reg_wr_en          (reg_wr_en),
        .reg_rd_en          (reg_rd_en),
        .reg_wr_data        (reg_wr_data),
        .reg_rd_data        (reg_rd_data),
        .stop_enter         (stop_enter),
        .ext_wake           (ext_wake),
        .cpu_clock_enable   (cpu_clock_enable),
        .stab_done          (stab_done),
        .watchdog_reset     (watchdog_reset),
        .capture_select     (capture_select),
        .timer_ext_clock_in (timer_ext_clock_in),
        .timer_capture_in   (timer_capture_in),
        .timer_pulse_out    (timer_pulse_out),
        .overflow_irq_ack   (overflow_irq_ack),
        .timer_overflow_irq (timer_overflow_irq),
        .timer_match_irq    (timer_match_irq)
    );

    // ==========================================================
    // shared tasks
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask

    // range compare for counts whose prescaler phase is free
    task automatic chk_rng(input int got, input int lo, input int hi);
        checked++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, lo);
        end
    endtask

    task automatic cyc(input int n);
        repeat (n) @(negedge clock);
    endtask

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr = a;
        reg_wr_data = d;
        reg_wr_en = 1'b1;
        @(negedge clock);
        reg_wr_en = 1'b0;
        // idle cycle so a following write never re-raises the strobe in the same step
        @(negedge clock);
    endtask

    // the expectation is queued before the strobe goes out
    task automatic rd(input logic [7:0] a, input logic chk, input logic [7:0] e);
        exp_q.push_back({chk, e});
        reg_addr = a;
        reg_rd_en = 1'b1;
        @(negedge clock);
        reg_rd_en = 1'b0;
        @(negedge clock);
    endtask

    function automatic logic pick(input int k);
        case (k)
            0: return timer_match_irq;
            1: return timer_pulse_out;
            2: return stab_done;
            3: return watchdog_reset;
            default: return timer_overflow_irq;
        endcase
    endfunction

    // bounded wait until a chosen output leaves level v
    task automatic wait_for(input int k, input logic v, input int lim, output int n);
        n = 0;
        while (pick(k) === v && n < lim) begin
            @(negedge clock);
            n++;
        end
        if (n >= lim) check(16'h0001, 16'h0000);
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // ==========================================================
    // read data lands one cycle after the strobe edge
    always @(posedge clock) rd_pend <= reg_rd_en;

    // oldest note is popped for each returned byte and compared when its check bit is set
    always @(negedge clock) begin
        if (rd_pend && exp_q.size() > 0) begin
            note = exp_q.pop_front();
            rd_last = reg_rd_data;
            if (note[8]) check({8'h00, reg_rd_data}, {8'h00, note[7:0]});
        end
    end

    // reset requests are counted, not waited on
    always @(negedge clock) begin
        if (watchdog_reset === 1'b1) wd_pulses++;
    end

    // hang guard, longer than the full sequence
    initial begin
        #2_450_000;
        fail_count++;
        end_sim();
    end

    // ==========================================================
    // main sequence
    localparam logic [7:0] CTL [4] = '{8'h8A, 8'h8A, 8'h4A, 8'h0A};
    localparam logic [7:0] REFV[4] = '{8'h00, 8'h05, 8'h00, 8'h00};
    localparam int         PER [4] = '{8, 48, 256, 4096};

    initial begin
        int n;
        int m;
        repeat (8) @(negedge clock);
        sys_rst = 1'b0;
        check(16'(cpu_clock_enable), 16'h0000);
        rd(wtm_pkg::TIMER_CONTROL_ADDR, 1'b1, wtm_pkg::TIMER_CONTROL_RST);
        rd(wtm_pkg::WATCHDOG_CONTROL_ADDR, 1'b1, 8'h00);
        rd(wtm_pkg::TIMER_REFERENCE_ADDR, 1'b1, 8'h00);
        rd(8'h10, 1'b1, 8'h00);
        // interval periods for each divider, ref zero is the edge case
        for (int i = 0; i < 4; i++) begin
            wr(8'hD4, REFV[i]);
            wr(8'hD2, CTL[i]);
            wait_for(0, 1'b0, PER[i] + 20, n);
            wait_for(1, timer_pulse_out, PER[i] + 20, n);
            wait_for(1, timer_pulse_out, PER[i] + 20, n);
            check(16'(n), 16'(PER[i]));
        end
        // pending bit: write one keeps, write zero clears
        rd(8'hD2, 1'b1, 8'h03);
        wr(8'hD2, 8'h03);
        rd(8'hD2, 1'b1, 8'h03);
        wr(8'hD2, 8'h02);
        rd(8'hD2, 1'b1, 8'h02);
        check(16'(timer_match_irq), 16'h0000);
        // pending without enable, irq stays masked
        wr(8'hD2, 8'h88);
        cyc(20);
        rd(8'hD2, 1'b1, 8'h81);
        check(16'(timer_match_irq), 16'h0000);
        // external clock, random edge count below the reference
        wr(8'hD4, 8'hFF);
        wr(8'hD2, 8'hC8);
        m = $random(seed) & 63;
        repeat (m) begin
            timer_ext_clock_in = 1'b1;
            cyc(2);
            timer_ext_clock_in = 1'b0;
            cyc(2);
        end
        rd(8'hD5, 1'b1, 8'(m));
        // pwm with overflow irq, duty over one full period
        wr(8'hD4, 8'h40);
        wr(8'hD2, 8'hBC);
        wait_for(4, 1'b0, 2100, n);
        overflow_irq_ack = 1'b1;
        cyc(1);
        overflow_irq_ack = 1'b0;
        cyc(1);
        check(16'(timer_overflow_irq), 16'h0000);
        m = 0;
        repeat (2048) begin
            @(negedge clock);
            m += (timer_pulse_out === 1'b1);
        end
        check(16'(m), 16'h0200);
        // capture pin not routed: no load, no pending
        wr(8'hD4, 8'h00);
        wr(8'hD2, 8'hAA);
        timer_capture_in = 1'b1;
        cyc(4);
        timer_capture_in = 1'b0;
        cyc(4);
        rd(8'hD2, 1'b1, 8'hA2);
        rd(8'hD4, 1'b1, 8'h00);
        capture_select = 1'b1;
        // rising then falling edge capture
        for (int k = 0; k < 2; k++) begin
            wr(8'hD2, k ? 8'h9A : 8'hAA);
            cyc(100);
            timer_capture_in = ~timer_capture_in;
            cyc(4);
            rd(8'hD4, 1'b0, 8'h00);
            chk_rng(rd_last, 12, 13);
            rd(8'hD2, 1'b1, k ? 8'h93 : 8'hA3);
            check(16'(timer_match_irq), 16'h0001);
        end
        // stop, wake at the preset /128 rate
        wr(8'hD3, 8'h08);
        stop_enter = 1'b1;
        cyc(1);
        stop_enter = 1'b0;
        cyc(4);
        check(16'(cpu_clock_enable), 16'h0000);
        ext_wake = 1'b1;
        cyc(1);
        ext_wake = 1'b0;
        wait_for(2, 1'b0, 2300, n);
        chk_rng(n, 2040, 2060);
        cyc(2);
        check(16'(cpu_clock_enable), 16'h0001);
        // clear then let the counter run out
        wr(8'hD3, 8'h0A);
        rd(8'hFD, 1'b1, 8'h00);
        wait_for(3, 1'b0, 34000, n);
        chk_rng(n, 32750, 32780);
        // signature key blocks the reset request
        wr(8'hD3, 8'hAA);
        rd(8'hD3, 1'b1, 8'hA8);
        m = wd_pulses;
        cyc(33000);
        check(16'(wd_pulses - m), 16'h0000);
        // divide by 1024 select, three ticks
        wr(8'hD3, 8'hA6);
        cyc(3 * 1024 + 500);
        rd(8'hFD, 1'b1, 8'h03);
        end_sim();
    end
endmodule

/* logic/wtm_core.sv */
`timescale 1ns/1ps
module wtm_core (
    // clock and reset
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // register port
    input  wire logic [7:0] reg_addr,
    input  wire logic       reg_wr_en,
    input  wire logic       reg_rd_en,
    input  wire logic [7:0] reg_wr_data,
    output logic      [7:0] reg_rd_data,
    // power management
    input  wire logic       stop_enter,
    input  wire logic       ext_wake,
    output logic            cpu_clock_enable,
    output logic            stab_done,
    output logic            watchdog_reset,
    // timer pins
    input  wire logic       capture_select,
    input  wire logic       timer_ext_clock_in,
    input  wire logic       timer_capture_in,
    output logic            timer_pulse_out,
    // timer interrupts
    input  wire logic       overflow_irq_ack,
    output logic            timer_overflow_irq,
    output logic            timer_match_irq
);

    // =================================================================
    // register decode
    // =================================================================
    wtm_pkg::wtm_wd_ctl_t wd_ctl_r;
    wtm_pkg::wtm_tm_ctl_t tm_ctl_r;
    logic [11:0]          wd_pre_r;
    logic [11:0]          tm_pre_r;
    logic [7:0]           stab_cnt_r;
    logic [7:0]           tm_cnt_r;
    logic [7:0]           tm_ref_r;
    logic                 stopped_r;
    logic                 stab_active_r;
    logic                 tm_pend_r;
    logic                 ovf_pend_r;
    logic                 ext_q_r;
    logic                 cap_q_r;
    logic                 pulse_r;

    logic wr_wd;
    logic wr_tm;
    logic wr_ref;
    logic wd_clear;
    logic wake_now;
    logic tm_clear;
    assign wr_wd    = reg_wr_en && (reg_addr == wtm_pkg::WATCHDOG_CONTROL_ADDR);
    assign wr_tm    = reg_wr_en && (reg_addr == wtm_pkg::TIMER_CONTROL_ADDR);
    assign wr_ref   = reg_wr_en && (reg_addr == wtm_pkg::TIMER_REFERENCE_ADDR);
    assign wake_now = stopped_r && ext_wake;
    assign wd_clear = (wr_wd && reg_wr_data[wtm_pkg::WD_CLEAR_BIT]) || wake_now;
    assign tm_clear = wr_tm && reg_wr_data[wtm_pkg::TMR_CLEAR_BIT];

    // =================================================================
    // watchdog stage
    // =================================================================
    logic [11:0] wd_mask;
    logic        wd_tick;
    logic        stab_end;
    logic        wd_enabled;

    always_comb begin
        case (wd_ctl_r.clk_sel)
            wtm_pkg::WD_SEL_4096: wd_mask = wtm_pkg::DIV4096_MASK;
            wtm_pkg::WD_SEL_1024: wd_mask = wtm_pkg::DIV1024_MASK;
            default:              wd_mask = wtm_pkg::DIV128_MASK;
        endcase
    end

    // oscillator is stopped in stop mode, so nothing counts
    assign wd_tick    = !stopped_r && !wd_clear && ((wd_pre_r & wd_mask) == wd_mask);
    assign wd_enabled = (wd_ctl_r.key != wtm_pkg::WD_DISABLE_KEY);
    assign stab_end   = stab_active_r && wd_tick && (stab_cnt_r[3:0] == wtm_pkg::STAB_NIB_TOP);

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wd_ctl_r <= wtm_pkg::WATCHDOG_CONTROL_RST;
        end else if (wr_wd) begin
            wd_ctl_r       <= reg_wr_data;
            wd_ctl_r.clear <= 1'b0;
            wd_ctl_r.rsvd  <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            wd_pre_r <= 12'h000;
        end else if (wd_clear) begin
            wd_pre_r <= 12'h000;
        end else if (!stopped_r) begin
            wd_pre_r <= wd_pre_r + 12'h001;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            stab_cnt_r <= 8'h00;
        end else if (wd_clear) begin
            stab_cnt_r <= 8'h00;
        end else if (wd_tick) begin
            stab_cnt_r <= stab_cnt_r + 8'h01;
        end
    end

    // stop mode entry and external wake
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            stopped_r <= 1'b0;
        end else if (wake_now) begin
            stopped_r <= 1'b0;
        end else if (stop_enter) begin
            stopped_r <= 1'b1;
        end
    end

    // stabilization window, also after chip reset
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            stab_active_r <= 1'b1;
        end else if (wake_now) begin
            stab_active_r <= 1'b1;
        end else if (stab_end) begin
            stab_active_r <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            watchdog_reset <= 1'b0;
            stab_done      <= 1'b0;
        end else begin
            watchdog_reset <= wd_enabled && wd_tick && (stab_cnt_r == wtm_pkg::COUNT_TOP);
            stab_done      <= stab_end;
        end
    end

    assign cpu_clock_enable = !stab_active_r && !stopped_r;

    // =================================================================
    // general timer
    // =================================================================
    logic       tm_tick;
    logic       ext_rise;
    logic       cap_in;
    logic       cap_evt;
    logic       match_now;
    logic       match_evt;
    logic       ovf_evt;
    logic       is_interval;

    assign ext_rise    = timer_ext_clock_in && !ext_q_r;
    assign cap_in      = capture_select && timer_capture_in;
    assign is_interval = (tm_ctl_r.mode == wtm_pkg::MODE_INTERVAL);
    assign match_now   = (tm_cnt_r == tm_ref_r);

    always_comb begin
        case (tm_ctl_r.clk_sel)
            wtm_pkg::TM_SEL_4096: tm_tick = &(tm_pre_r | ~wtm_pkg::DIV4096_MASK);
            wtm_pkg::TM_SEL_256:  tm_tick = &(tm_pre_r | ~wtm_pkg::DIV256_MASK);
            wtm_pkg::TM_SEL_8:    tm_tick = &(tm_pre_r | ~wtm_pkg::DIV8_MASK);
            default:              tm_tick = ext_rise;
        endcase
    end

    always_comb begin
        case (tm_ctl_r.mode)
            wtm_pkg::MODE_CAP_RISE: cap_evt = cap_in && !cap_q_r;
            wtm_pkg::MODE_CAP_FALL: cap_evt = !cap_in && cap_q_r;
            default:                cap_evt = 1'b0;
        endcase
    end

    // match in interval and pwm modes
    assign match_evt = tm_tick && !tm_clear && match_now && !stopped_r
                       && (is_interval || (tm_ctl_r.mode == wtm_pkg::MODE_PWM));
    assign ovf_evt   = tm_tick && !tm_clear && !stopped_r && (tm_cnt_r == wtm_pkg::COUNT_TOP)
                       && !(is_interval && match_now);

    // input history for edge detectors
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ext_q_r <= 1'b0;
            cap_q_r <= 1'b0;
        end else begin
            ext_q_r <= timer_ext_clock_in;
            cap_q_r <= cap_in;
        end
    end

    // free running timer prescaler
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tm_pre_r <= 12'h000;
        end else if (!stopped_r) begin
            tm_pre_r <= tm_pre_r + 12'h001;
        end
    end

    // control resets to zero; mode field
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tm_ctl_r <= wtm_pkg::TIMER_CONTROL_RST;
        end else if (wr_tm) begin
            tm_ctl_r       <= reg_wr_data;
            tm_ctl_r.clear <= 1'b0;
            tm_ctl_r.pend  <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tm_cnt_r <= 8'h00;
        end else if (tm_clear) begin
            tm_cnt_r <= 8'h00;
        end else if (tm_tick && !stopped_r) begin
            if (is_interval && match_now) begin
                tm_cnt_r <= 8'h00;
            end else begin
                tm_cnt_r <= tm_cnt_r + 8'h01;
            end
        end
    end

    // capture has priority over a software write
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tm_ref_r <= wtm_pkg::TIMER_REFERENCE_RST;
        end else if (cap_evt) begin
            tm_ref_r <= tm_cnt_r;
        end else if (wr_ref) begin
            tm_ref_r <= reg_wr_data;
        end
    end

    // set wins over a clearing write; write zero clears
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            tm_pend_r <= 1'b0;
        end else if (match_evt || cap_evt) begin
            tm_pend_r <= 1'b1;
        end else if (wr_tm && !reg_wr_data[wtm_pkg::TMR_PEND_BIT]) begin
            tm_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            ovf_pend_r <= 1'b0;
        end else if (ovf_evt) begin
            ovf_pend_r <= 1'b1;
        end else if (overflow_irq_ack) begin
            ovf_pend_r <= 1'b0;
        end
    end

    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            pulse_r <= 1'b0;
        end else if (tm_ctl_r.mode == wtm_pkg::MODE_PWM) begin
            pulse_r <= (tm_ref_r > tm_cnt_r);
        end else if (match_evt) begin
            pulse_r <= !pulse_r;
        end
    end

    assign timer_pulse_out    = pulse_r;
    // match irq gated by its enable
    assign timer_match_irq    = tm_pend_r && tm_ctl_r.match_en;
    assign timer_overflow_irq = ovf_pend_r && tm_ctl_r.ovf_en;

    // register read, one cycle after the strobe; unmapped reads zero
    always_ff @(posedge clock or posedge sys_rst) begin
        if (sys_rst) begin
            reg_rd_data <= 8'h00;
        end else if (reg_rd_en) begin
            case (reg_addr)
                wtm_pkg::TIMER_CONTROL_ADDR:    reg_rd_data <= {tm_ctl_r[7:1], tm_pend_r};
                wtm_pkg::WATCHDOG_CONTROL_ADDR: reg_rd_data <= wd_ctl_r;
                wtm_pkg::TIMER_REFERENCE_ADDR:  reg_rd_data <= tm_ref_r;
                wtm_pkg::TIMER_COUNT_ADDR:      reg_rd_data <= tm_cnt_r;
                wtm_pkg::STAB_COUNT_ADDR:       reg_rd_data <= stab_cnt_r;
                default:                        reg_rd_data <= 8'h00;
            endcase
        end
    end

    // =================================================================
    // checks
    // =================================================================
    sequence s_wd_top;
        wd_tick && wd_enabled && (stab_cnt_r == wtm_pkg::COUNT_TOP);
    endsequence
    sequence s_int_match;
        match_evt && is_interval && !wr_tm;
    endsequence

    property p_wd_ovf;
        @(posedge clock) disable iff (sys_rst) s_wd_top |=> watchdog_reset;
    endproperty
    a_wd_ovf: assert property (p_wd_ovf) else $error("watchdog overflow gave no reset");

    property p_wd_off;
        @(posedge clock) disable iff (sys_rst)
            (wd_ctl_r.key == wtm_pkg::WD_DISABLE_KEY) && !wr_wd |=> !watchdog_reset;
    endproperty
    a_wd_off: assert property (p_wd_off) else $error("reset while watchdog disabled");

    property p_wd_clear;
        @(posedge clock) disable iff (sys_rst)
            wr_wd && reg_wr_data[wtm_pkg::WD_CLEAR_BIT] |=> !(|stab_cnt_r) && !(|wd_pre_r);
    endproperty
    a_wd_clear: assert property (p_wd_clear) else $error("watchdog clear missed");

    property p_stab_end;
        @(posedge clock) disable iff (sys_rst)
            stab_end && !stop_enter |=> stab_done && cpu_clock_enable;
    endproperty
    a_stab_end: assert property (p_stab_end) else $error("cpu clock not released");

    property p_tm_clear;
        @(posedge clock) disable iff (sys_rst) tm_clear |=> (tm_cnt_r == 8'h00);
    endproperty
    a_tm_clear: assert property (p_tm_clear) else $error("timer clear missed");

    property p_int_match;
        @(posedge clock) disable iff (sys_rst)
            s_int_match |=> (tm_cnt_r == 8'h00) && tm_pend_r && (pulse_r != $past(pulse_r));
    endproperty
    a_int_match: assert property (p_int_match) else $error("interval match wrong");

    property p_pwm_out;
        @(posedge clock) disable iff (sys_rst)
            (tm_ctl_r.mode == wtm_pkg::MODE_PWM) && !wr_tm
            |=> timer_pulse_out == ($past(tm_ref_r) > $past(tm_cnt_r));
    endproperty
    a_pwm_out: assert property (p_pwm_out) else $error("pwm level wrong");

    property p_capture;
        @(posedge clock) disable iff (sys_rst)
            cap_evt && !tm_clear |=> (tm_ref_r == $past(tm_cnt_r)) && tm_pend_r;
    endproperty
    a_capture: assert property (p_capture) else $error("capture value wrong");

    property p_ovf_irq;
        @(posedge clock) disable iff (sys_rst)
            ovf_evt && tm_ctl_r.ovf_en && !wr_tm |=> timer_overflow_irq;
    endproperty
    a_ovf_irq: assert property (p_ovf_irq) else $error("overflow irq missing");

endmodule

/* pkg/wtm_pkg.sv */
// =====================================================================
// shared constants and carriers
// =====================================================================
package wtm_pkg;

    // register addresses
    localparam logic [7:0] TIMER_CONTROL_ADDR    = 8'hD2;
    localparam logic [7:0] WATCHDOG_CONTROL_ADDR = 8'hD3;
    localparam logic [7:0] TIMER_REFERENCE_ADDR  = 8'hD4;
    localparam logic [7:0] TIMER_COUNT_ADDR      = 8'hD5;
    localparam logic [7:0] STAB_COUNT_ADDR       = 8'hFD;

    // values after reset
    localparam logic [7:0] TIMER_CONTROL_RST     = 8'h00;
    localparam logic [7:0] WATCHDOG_CONTROL_RST  = 8'h00;
    localparam logic [7:0] TIMER_REFERENCE_RST   = 8'h00;

    // field positions
    localparam int WD_CLEAR_BIT    = 1;
    localparam int TMR_CLEAR_BIT   = 3;
    localparam int TMR_PEND_BIT    = 0;

    // watchdog disable signature in the upper nibble
    localparam logic [3:0] WD_DISABLE_KEY = 4'hA;

    // prescaler tap masks, divide-by-n minus one
    localparam logic [11:0] DIV4096_MASK = 12'hFFF;
    localparam logic [11:0] DIV1024_MASK = 12'h3FF;
    localparam logic [11:0] DIV256_MASK  = 12'h0FF;
    localparam logic [11:0] DIV128_MASK  = 12'h07F;
    localparam logic [11:0] DIV8_MASK    = 12'h007;

    // watchdog clock select codes
    localparam logic [1:0] WD_SEL_4096 = 2'h0;
    localparam logic [1:0] WD_SEL_1024 = 2'h1;

    // timer clock select codes
    localparam logic [1:0] TM_SEL_4096 = 2'h0;
    localparam logic [1:0] TM_SEL_256  = 2'h1;
    localparam logic [1:0] TM_SEL_8    = 2'h2;

    // timer mode codes
    localparam logic [1:0] MODE_INTERVAL = 2'h0;
    localparam logic [1:0] MODE_CAP_FALL = 2'h1;
    localparam logic [1:0] MODE_CAP_RISE = 2'h2;
    localparam logic [1:0] MODE_PWM      = 2'h3;

    // counter limits
    localparam logic [7:0] COUNT_TOP     = 8'hFF;
    localparam logic [3:0] STAB_NIB_TOP  = 4'hF;

    typedef struct packed {
        logic [3:0] key;
        logic [1:0] clk_sel;
        logic       clear;
        logic       rsvd;
    } wtm_wd_ctl_t;

    typedef struct packed {
        logic [1:0] clk_sel;
        logic [1:0] mode;
        logic       clear;
        logic       ovf_en;
        logic       match_en;
        logic       pend;
    } wtm_tm_ctl_t;

endpackage
